// [verilog/spd_map.svh]
// Register offsets, field positions, reset values and timing counts of the stepper logic
`ifndef SPD_MAP_SVH
`define SPD_MAP_SVH
`define SPD_OFF_GLOBAL_CONFIG_REG      8'h00
`define SPD_OFF_VELOCITY   8'h04
`define SPD_OFF_STATUS     8'h08
`define SPD_OFF_STEPINT    8'h0C
`define SPD_OFF_MICROSTEP_POSITION_COUNT      8'h10
`define SPD_OFF_STEPCFG    8'h14
`define SPD_GC_DIAG_INDEX  1
`define SPD_GC_DIAG_STEP   2
`define SPD_GC_DRV_EN      0
`define SPD_GC_RESET       32'h0000_0000
`define SPD_ST_OT          0
`define SPD_ST_OTPW        1
`define SPD_ST_COIL_A_GROUND_SHORT_FLAG        2
`define SPD_ST_COIL_B_GROUND_SHORT_FLAG        3
`define SPD_ST_COIL_A_SUPPLY_SHORT_FLAG       4
`define SPD_ST_COIL_B_SUPPLY_SHORT_FLAG       5
`define SPD_ST_OLA         6
`define SPD_ST_OLB         7
`define SPD_ST_UV          8
`define SPD_ST_DRV_OFF     9
`define SPD_VEL_SHIFT      24
`define SPD_MICROSTEP_POSITION_COUNT_WIDTH    10
`define SPD_SHORT_RETRIES  3
`define SPD_INDEX_POS      10'h000
`define SPD_STEPINT_MAX    20'hF_FFFF
`endif

// [verilog/spd_pkg.sv]
// Types shared by the stepper logic
`default_nettype none
package spd_pkg;
   typedef struct packed {
      logic ot;
      logic otpw;
      logic [1:0] s2g;
      logic [1:0] s2vs;
      logic [1:0] ol;
      logic uv;
   } spd_sense_s;
   typedef enum logic [1:0] {
      SPD_DRV_ON,
      SPD_DRV_OT_OFF,
      SPD_DRV_SHORT_OFF
   } spd_drv_e;
endpackage : spd_pkg
`default_nettype wire

// [verilog/spd_short_filt.sv]
// Short detection retry filter for one bridge fault input
`default_nettype none
`include "spd_map.svh"
module spd_short_filt #(
   parameter int RETRIES = `SPD_SHORT_RETRIES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic detect_i,
   output logic confirmed_o
);
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic conf_reg;
   logic conf_next;
   logic det_d_reg;
   logic det_rise;

   assign det_rise = detect_i & ~det_d_reg;

   always_comb begin
      cnt_next = cnt_reg;
      conf_next = conf_reg;
      if (clear_i) begin
         cnt_next = 3'h0;
         conf_next = 1'b0;
      end else if (det_rise && !conf_reg) begin
         // Retries absorb single spurious hits; the fourth detection confirms
         if (cnt_reg == 3'(RETRIES)) begin
            conf_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 3'h0;
         conf_reg <= 1'b0;
         det_d_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         conf_reg <= conf_next;
         det_d_reg <= detect_i;
      end
   end

   assign confirmed_o = conf_reg;

   retry_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(conf_reg) |-> $past(cnt_reg) == 3'(RETRIES))
      else $error("short confirmed before retries done");
endmodule : spd_short_filt
`default_nettype wire

// [verilog/spd_top.sv]
// Stepper index, pulse generator, microstep counter and diagnostic flags
//
// Our own choices: the Wishbone slave port and the register addresses.
`default_nettype none
`include "spd_map.svh"
module spd_top #(
   parameter int VEL_WIDTH = 24,
   parameter int INT_WIDTH = 20
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic step_i,
   input wire logic dir_i,
   input wire spd_pkg::spd_sense_s sense_i,
   output logic bridge_en_o,
   output logic diag_o,
   output logic [9:0] microstep_position_count_o
);
   localparam int SW = `SPD_MICROSTEP_POSITION_COUNT_WIDTH;

   // Register state
   logic [31:0] global_config_reg, global_config_reg_next;
   logic [VEL_WIDTH-1:0] signed_velocity_value_reg, vel_next;
   logic [8:0] step_width_reg, step_width_next;
   logic [31:0] rdata_reg, rdata_next;
   logic ack_reg, ack_next;
   // Motion state
   logic [SW-1:0] microstep_position_count_reg, microstep_position_count_next;
   logic [VEL_WIDTH-1:0] accu_reg, accu_next;
   logic [INT_WIDTH-1:0] tcnt_reg, tcnt_next;
   logic [INT_WIDTH-1:0] measured_step_interval_reg, msi_next;
   logic step_d_reg, step_d_next;
   logic diag_reg, diag_next;
   logic step_tgl_reg, step_tgl_next;
   // Protection state
   spd_pkg::spd_drv_e drv_reg, drv_next;
   logic [9:0] status_reg, status_next;
   logic en_d_reg;

   logic wr_stb, rd_stb;
   logic drv_en, en_rise, short_clear;
   logic [3:0] short_conf;
   logic [3:0] short_det;
   logic any_short;
   logic ext_step, int_step, do_step, int_dir, step_dir;
   logic [VEL_WIDTH:0] accu_sum;
   logic [VEL_WIDTH-1:0] vel_abs;
   logic [8:0] step_w;

   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
   assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg;
   assign drv_en = global_config_reg[`SPD_GC_DRV_EN];
   assign en_rise = drv_en & ~en_d_reg;
   // Disabling the driver rearms short detection
   assign short_clear = ~drv_en;

   // Bit order matches the filter order: ground A, ground B, supply A, supply B
   assign short_det = {sense_i.s2vs, sense_i.s2g};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_short
         spd_short_filt u_filt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .clear_i(short_clear),
            .detect_i(short_det[g]),
            .confirmed_o(short_conf[g])
         );
      end
   endgenerate
   assign any_short = |short_conf;

   // Register bus
   always_comb begin
      global_config_reg_next = global_config_reg;
      vel_next = signed_velocity_value_reg;
      step_width_next = step_width_reg;
      rdata_next = 32'h0000_0000;
      ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
      if (wr_stb) begin
         if (wb_adr_i == `SPD_OFF_GLOBAL_CONFIG_REG) begin
            if (wb_sel_i[0]) global_config_reg_next[7:0] = wb_dat_i[7:0];
         end else if (wb_adr_i == `SPD_OFF_VELOCITY) begin
            // New velocity takes effect at once, no ramp
            for (int b = 0; b < 3; b++) begin
               if (wb_sel_i[b]) vel_next[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            end
         end else if (wb_adr_i == `SPD_OFF_STEPCFG) begin
            if (wb_sel_i[0]) step_width_next[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) step_width_next[8] = wb_dat_i[8];
         end
      end
      if (rd_stb) begin
         if (wb_adr_i == `SPD_OFF_GLOBAL_CONFIG_REG) begin
            rdata_next = global_config_reg;
         end else if (wb_adr_i == `SPD_OFF_VELOCITY) begin
            rdata_next = {{(32-VEL_WIDTH){1'b0}}, signed_velocity_value_reg};
         end else if (wb_adr_i == `SPD_OFF_STATUS) begin
            rdata_next = {22'h00_0000, status_reg};
         end else if (wb_adr_i == `SPD_OFF_STEPINT) begin
            rdata_next = {{(32-INT_WIDTH){1'b0}}, measured_step_interval_reg};
         end else if (wb_adr_i == `SPD_OFF_MICROSTEP_POSITION_COUNT) begin
            rdata_next = {22'h00_0000, microstep_position_count_reg};
         end else if (wb_adr_i == `SPD_OFF_STEPCFG) begin
            rdata_next = {23'h00_0000, step_width_reg};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         global_config_reg <= `SPD_GC_RESET;
         signed_velocity_value_reg <= '0;
         step_width_reg <= 9'h001;
         rdata_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
      end else begin
         global_config_reg <= global_config_reg_next;
         signed_velocity_value_reg <= vel_next;
         step_width_reg <= step_width_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
      end
   end

   // Step generation: accumulator overflows at |v| * fclk / 2^24
   assign vel_abs = signed_velocity_value_reg[VEL_WIDTH-1] ?
      (~signed_velocity_value_reg + 1'b1) : signed_velocity_value_reg;
   assign accu_sum = {1'b0, accu_reg} + {1'b0, vel_abs};
   assign int_step = accu_sum[VEL_WIDTH];
   assign int_dir = signed_velocity_value_reg[VEL_WIDTH-1];
   assign ext_step = step_i & ~step_d_reg;
   // Internal generator has priority while a velocity is set
   assign do_step = (signed_velocity_value_reg != '0) ? int_step : ext_step;
   assign step_dir = (signed_velocity_value_reg != '0) ? int_dir : dir_i;
   // Internal generator walks at full resolution
   assign step_w = (signed_velocity_value_reg != '0) ? 9'h001 : step_width_reg;

   always_comb begin
      accu_next = accu_sum[VEL_WIDTH-1:0];
      step_d_next = step_i;
      microstep_position_count_next = microstep_position_count_reg;
      tcnt_next = (tcnt_reg == `SPD_STEPINT_MAX) ? tcnt_reg : tcnt_reg + 1'b1;
      msi_next = measured_step_interval_reg;
      step_tgl_next = step_tgl_reg;
      diag_next = 1'b0;
      if (do_step && drv_reg == spd_pkg::SPD_DRV_ON) begin
         // Modulo 1024 wrap falls out of the counter width
         if (!step_dir) begin
            microstep_position_count_next = microstep_position_count_reg + SW'(step_w);
         end else begin
            microstep_position_count_next = microstep_position_count_reg - SW'(step_w);
         end
         step_tgl_next = ~step_tgl_reg;
      end
      if (do_step) begin
         // Cycles per step scaled down to cycles per 1/256 microstep
         msi_next = INT_WIDTH'(tcnt_reg / INT_WIDTH'(step_w));
         // Restart at one so the count equals clocks between steps
         tcnt_next = INT_WIDTH'(1);
      end
      if (global_config_reg[`SPD_GC_DIAG_STEP]) begin
         diag_next = step_tgl_next;
      end else if (global_config_reg[`SPD_GC_DIAG_INDEX]) begin
         // Position 0: coil B sine zero going positive, coil A cosine maximum
         diag_next = (microstep_position_count_next == `SPD_INDEX_POS);
      end else begin
         // Disabled, shut down, shorted or undervoltage; warnings and open load excluded
         diag_next = status_next[`SPD_ST_DRV_OFF] | status_next[`SPD_ST_OT] |
            (|status_next[`SPD_ST_COIL_B_SUPPLY_SHORT_FLAG:`SPD_ST_COIL_A_GROUND_SHORT_FLAG]) | status_next[`SPD_ST_UV];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accu_reg <= '0;
         step_d_reg <= 1'b0;
         microstep_position_count_reg <= '0;
         tcnt_reg <= '0;
         measured_step_interval_reg <= `SPD_STEPINT_MAX;
         step_tgl_reg <= 1'b0;
         diag_reg <= 1'b0;
      end else begin
         accu_reg <= accu_next;
         step_d_reg <= step_d_next;
         microstep_position_count_reg <= microstep_position_count_next;
         tcnt_reg <= tcnt_next;
         measured_step_interval_reg <= msi_next;
         step_tgl_reg <= step_tgl_next;
         diag_reg <= diag_next;
      end
   end

   // Protection
   always_comb begin
      drv_next = drv_reg;
      status_next = status_reg;
      status_next[`SPD_ST_OT] = sense_i.ot | (drv_reg == spd_pkg::SPD_DRV_OT_OFF);
      status_next[`SPD_ST_OTPW] = sense_i.otpw;
      status_next[`SPD_ST_COIL_A_GROUND_SHORT_FLAG] = short_conf[0];
      status_next[`SPD_ST_COIL_B_GROUND_SHORT_FLAG] = short_conf[1];
      status_next[`SPD_ST_COIL_A_SUPPLY_SHORT_FLAG] = short_conf[2];
      status_next[`SPD_ST_COIL_B_SUPPLY_SHORT_FLAG] = short_conf[3];
      status_next[`SPD_ST_OLA] = sense_i.ol[0];
      status_next[`SPD_ST_OLB] = sense_i.ol[1];
      status_next[`SPD_ST_UV] = sense_i.uv;
      case (drv_reg)
         spd_pkg::SPD_DRV_ON: begin
            if (any_short) begin
               drv_next = spd_pkg::SPD_DRV_SHORT_OFF;
            end else if (sense_i.ot) begin
               drv_next = spd_pkg::SPD_DRV_OT_OFF;
            end
         end
         spd_pkg::SPD_DRV_OT_OFF: begin
            // Hysteresis: wait until even the pre-warning has cleared
            if (any_short) begin
               drv_next = spd_pkg::SPD_DRV_SHORT_OFF;
            end else if (!sense_i.ot && !sense_i.otpw) begin
               drv_next = spd_pkg::SPD_DRV_ON;
            end
         end
         spd_pkg::SPD_DRV_SHORT_OFF: begin
            if (en_rise) drv_next = spd_pkg::SPD_DRV_ON;
         end
         default: drv_next = spd_pkg::SPD_DRV_ON;
      endcase
      status_next[`SPD_ST_DRV_OFF] = (drv_next != spd_pkg::SPD_DRV_ON) | ~drv_en;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drv_reg <= spd_pkg::SPD_DRV_ON;
         status_reg <= 10'h200;
         en_d_reg <= 1'b0;
         bridge_en_o <= 1'b0;
      end else begin
         drv_reg <= drv_next;
         status_reg <= status_next;
         en_d_reg <= drv_en;
         bridge_en_o <= drv_en & (drv_next == spd_pkg::SPD_DRV_ON);
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign diag_o = diag_reg;
   assign microstep_position_count_o = microstep_position_count_reg;

   ot_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      drv_reg == spd_pkg::SPD_DRV_OT_OFF |-> !bridge_en_o)
      else $error("bridge on during thermal shutdown");
   ot_hyst_a: assert property (@(posedge clk_i) disable iff (rst_i)
      drv_reg == spd_pkg::SPD_DRV_OT_OFF && sense_i.otpw && !any_short
      |=> drv_reg == spd_pkg::SPD_DRV_OT_OFF)
      else $error("restart above pre-warning level");
   short_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      any_short |=> drv_reg == spd_pkg::SPD_DRV_SHORT_OFF ##1 !bridge_en_o)
      else $error("short did not switch bridges off");
   short_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      drv_reg == spd_pkg::SPD_DRV_SHORT_OFF && drv_en && en_d_reg
      |=> drv_reg == spd_pkg::SPD_DRV_SHORT_OFF)
      else $error("short latch released without re-enable");
   ol_info_a: assert property (@(posedge clk_i) disable iff (rst_i)
      drv_reg == spd_pkg::SPD_DRV_ON && !any_short && !sense_i.ot
      |=> drv_reg == spd_pkg::SPD_DRV_ON)
      else $error("open load changed driver state");
   step_move_a: assert property (@(posedge clk_i) disable iff (rst_i)
      do_step && drv_reg == spd_pkg::SPD_DRV_ON && !step_dir
      |=> microstep_position_count_reg == $past(microstep_position_count_reg) + SW'($past(step_w)))
      else $error("counter did not advance by step width");
   wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      microstep_position_count_reg == 10'h3FF && do_step && !step_dir && step_w == 9'h001 &&
      drv_reg == spd_pkg::SPD_DRV_ON |=> microstep_position_count_reg == 10'h000)
      else $error("counter did not wrap to zero");
   index_a: assert property (@(posedge clk_i) disable iff (rst_i)
      global_config_reg[`SPD_GC_DIAG_INDEX] && !global_config_reg[`SPD_GC_DIAG_STEP]
      ##1 1'b1 |-> diag_o == (microstep_position_count_reg == `SPD_INDEX_POS))
      else $error("index output mismatch");
   diag_tgl_a: assert property (@(posedge clk_i) disable iff (rst_i)
      global_config_reg[`SPD_GC_DIAG_STEP] && $past(global_config_reg[`SPD_GC_DIAG_STEP]) &&
      do_step && drv_reg == spd_pkg::SPD_DRV_ON |=> diag_o != $past(diag_o))
      else $error("step toggle missing");
   int_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      signed_velocity_value_reg == '0 && !ext_step |=> $stable(microstep_position_count_reg))
      else $error("count moved without velocity or step");

   short_cov_c: cover property (@(posedge clk_i) $rose(any_short));
   ot_cov_c: cover property (@(posedge clk_i) $fell(drv_reg == spd_pkg::SPD_DRV_OT_OFF));
   wrap_cov_c: cover property (@(posedge clk_i) $past(microstep_position_count_reg) == 10'h3FF && microstep_position_count_reg == 10'h000);
   index_cov_c: cover property (@(posedge clk_i) global_config_reg[1] && diag_o);
endmodule : spd_top
`default_nettype wire

// [verification/spd_host_model.sv]
// Host side model: register bus master driving the stepper logic
`default_nettype none
module spd_host_model (
   input wire logic clk_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i,
   output logic [7:0] wb_adr_o,
   output logic [31:0] wb_dat_o,
   output logic [3:0] wb_sel_o,
   output logic wb_we_o,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic timeout_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      wb_adr_o = 8'h0;
      wb_dat_o = 32'h0;
      wb_sel_o = 4'hF;
      wb_we_o = 1'b0;
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      timeout_o = 1'b0;
   end
   // One classic cycle; waits for ack however long the slave takes
   task automatic xfer(input logic [7:0] adr, input logic we, input logic [31:0] wd,
                       output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_adr_o <= adr;
      wb_we_o <= we;
      wb_dat_o <= wd;
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
         // Flag a slow slave but keep holding; the watchdog ends a hang
         if (n == 20) timeout_o <= 1'b1;
      end while (wb_ack_i !== 1'b1);
      rd = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
      // Bus idle for a cycle before the next request
      @(posedge clk_i);
   endtask : xfer
endmodule : spd_host_model
`default_nettype wire

// [verification/stepper_index_pulsegen_diag_test.sv]
// Self-checking bench for the stepper index, pulse generator and diagnostics
`default_nettype none
`include "spd_map.svh"
module stepper_index_pulsegen_diag_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] wb_adr;
   logic [31:0] wb_wdat;
   logic [31:0] wb_rdat;
   logic [3:0] wb_sel;
   logic wb_we, wb_cyc, wb_stb, wb_ack, tmo;
   logic step_i = 1'b0;
   logic dir_i = 1'b0;
   spd_pkg::spd_sense_s sense = '0;
   logic bridge_en, diag;
   logic [9:0] cnt, c0, dc;
   logic d0;
   int err_count = 0;
   int checks = 0;
   int pos[4] = '{5, 6, 3, 4};
   always #50 clk_i = ~clk_i;
   spd_host_model host (.clk_i(clk_i), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack),
      .wb_adr_o(wb_adr), .wb_dat_o(wb_wdat), .wb_sel_o(wb_sel), .wb_we_o(wb_we),
      .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .timeout_o(tmo));
   spd_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
      .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .step_i(step_i), .dir_i(dir_i),
      .sense_i(sense), .bridge_en_o(bridge_en), .diag_o(diag),
      .microstep_position_count_o(cnt));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      host.xfer(a, 1'b1, d, r);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string what);
      logic [31:0] r;
      host.xfer(a, 1'b0, 32'h0, r);
      chk(r & m, e, what);
   endtask : rd_chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   // Direction settles a cycle ahead of the step edge
   task automatic step(input logic d);
      @(posedge clk_i);
      dir_i <= d;
      @(posedge clk_i);
      step_i <= 1'b1;
      cyc(2);
      step_i <= 1'b0;
      cyc(3);
   endtask : step
   task automatic sense_set(input logic [8:0] v);
      @(posedge clk_i);
      sense <= v;
      cyc(4);
   endtask : sense_set
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #1_000_000;
      err_count++;
      report_and_stop();
   end
   initial begin
      cyc(16);
      rst_i <= 1'b0;
      rd_chk(`SPD_OFF_STATUS, 32'hFFFF_FFFF, 32'h200, "status at reset");
      rd_chk(`SPD_OFF_GLOBAL_CONFIG_REG, 32'hFFFF_FFFF, `SPD_GC_RESET, "config at reset");
      rd_chk(`SPD_OFF_STEPINT, 32'hFFFF_FFFF, 32'hF_FFFF, "interval at reset");
      rd_chk(`SPD_OFF_STEPCFG, 32'hFFFF_FFFF, 32'h1, "width at reset");
      chk(cnt, 32'h0, "count at reset");
      chk(bridge_en, 32'h0, "bridges at reset");
      chk(diag, 32'h1, "diag while disabled");
      wr(`SPD_OFF_GLOBAL_CONFIG_REG, 32'h1);
      cyc(3);
      chk(bridge_en, 32'h1, "bridges enabled");
      chk(diag, 32'h0, "diag idle");
      step(1'b0);
      chk(cnt, 32'h1, "step up");
      step(1'b1);
      chk(cnt, 32'h0, "step down");
      step(1'b1);
      chk(cnt, 32'h3FF, "wrap below zero");
      wr(`SPD_OFF_STEPCFG, 32'h100);
      step(1'b0);
      chk(cnt, 32'hFF, "wide step wraps up");
      step(1'b1);
      wr(`SPD_OFF_STEPCFG, 32'h1);
      wr(`SPD_OFF_GLOBAL_CONFIG_REG, 32'h3);
      step(1'b0);
      cyc(2);
      chk(cnt, 32'h0, "at sequence zero");
      chk(diag, 32'h1, "index at zero");
      // Fullstep width: index marks only one of every four fullsteps
      wr(`SPD_OFF_STEPCFG, 32'h100);
      for (int i = 1; i <= 4; i++) begin
         step(1'b0);
         chk(diag, (i == 4) ? 32'h1 : 32'h0, "index per period");
      end
      wr(`SPD_OFF_STEPCFG, 32'h1);
      step(1'b0);
      chk(diag, 32'h0, "index off zero");
      rd_chk(`SPD_OFF_MICROSTEP_POSITION_COUNT, 32'h3FF, 32'h1, "count readback");
      wr(`SPD_OFF_GLOBAL_CONFIG_REG, 32'h5);
      cyc(2);
      d0 = diag;
      for (int i = 0; i < 3; i++) begin
         step(1'b1);
         d0 = ~d0;
         chk(diag, d0, "step toggle");
      end
      // 2^20 per clock carries every 16 clocks
      wr(`SPD_OFF_VELOCITY, 32'h0010_0000);
      cyc(20);
      c0 = cnt;
      cyc(160);
      dc = cnt - c0;
      chk(dc, 32'hA, "forward rate");
      rd_chk(`SPD_OFF_STEPINT, 32'hF_FFFF, 32'h10, "measured interval");
      wr(`SPD_OFF_VELOCITY, 32'h00F0_0000);
      cyc(20);
      c0 = cnt;
      cyc(160);
      dc = c0 - cnt;
      chk(dc, 32'hA, "reverse rate");
      wr(`SPD_OFF_VELOCITY, 32'h0);
      cyc(5);
      c0 = cnt;
      cyc(50);
      chk(cnt, c0, "stopped");
      wr(`SPD_OFF_GLOBAL_CONFIG_REG, 32'h1);
      sense_set(9'h080);
      chk(bridge_en, 32'h1, "prewarning keeps driver");
      rd_chk(`SPD_OFF_STATUS, 32'h3FF, 32'h2, "prewarning flag");
      sense_set(9'h180);
      chk(bridge_en, 32'h0, "thermal shutdown");
      chk(diag, 32'h1, "diag on shutdown");
      rd_chk(`SPD_OFF_STATUS, 32'h3FF, 32'h203, "shutdown flags");
      sense_set(9'h080);
      chk(bridge_en, 32'h0, "hysteresis");
      sense_set(9'h000);
      chk(bridge_en, 32'h1, "thermal restart");
      // Open load flags copy the sense inputs whether moving or not
      wr(`SPD_OFF_VELOCITY, 32'h0010_0000);
      sense_set(9'h006);
      chk(bridge_en, 32'h1, "open load no action");
      chk(diag, 32'h0, "open load not a fault");
      rd_chk(`SPD_OFF_STATUS, 32'h3FF, 32'hC0, "open load flags");
      sense_set(9'h001);
      rd_chk(`SPD_OFF_STATUS, 32'h1FF, 32'h100, "undervoltage flag");
      chk(diag, 32'h1, "diag on undervoltage");
      sense_set(9'h000);
      wr(`SPD_OFF_VELOCITY, 32'h0);
      for (int i = 0; i < 4; i++) begin
         repeat (3) begin
            sense_set(9'h001 << pos[i]);
            sense_set(9'h000);
         end
         chk(bridge_en, 32'h1, "retries tolerated");
         sense_set(9'h001 << pos[i]);
         chk(bridge_en, 32'h0, "short confirmed");
         sense_set(9'h000);
         rd_chk(`SPD_OFF_STATUS, 32'h3FF, 32'h200 | (32'h4 << i), "short flag");
         chk(bridge_en, 32'h0, "short latched");
         wr(`SPD_OFF_GLOBAL_CONFIG_REG, 32'h0);
         wr(`SPD_OFF_GLOBAL_CONFIG_REG, 32'h1);
         cyc(3);
         chk(bridge_en, 32'h1, "restart after short");
         rd_chk(`SPD_OFF_STATUS, 32'h3FF, 32'h0, "short flag cleared");
      end
      rd_chk(8'h20, 32'hFFFF_FFFF, 32'h0, "unmapped read");
      wr(8'h20, 32'hFFFF_FFFF);
      rd_chk(`SPD_OFF_GLOBAL_CONFIG_REG, 32'h7, 32'h1, "unmapped write ignored");
      chk(tmo, 32'h0, "bus answered");
      report_and_stop();
   end
endmodule : stepper_index_pulsegen_diag_test
`default_nettype wire
